/* File: include/uie_pkg.sv */
// ==========================================================
// Register map
package uie_pkg;
   localparam int unsigned ADDR_W   = 12;
   localparam logic [11:0] OFF_STAT = 12'h100; // Sticky event status, read clears
   localparam logic [11:0] OFF_INTEN = 12'h300; // Direct interrupt enable
   localparam logic [11:0] OFF_SET  = 12'h304;
   localparam logic [11:0] OFF_CLR  = 12'h308;
   localparam logic [11:0] OFF_ERR  = 12'h480;
   localparam logic [11:0] OFF_ENA  = 12'h500;
   localparam logic [11:0] OFF_CFG  = 12'h600; // Parity enable and bit divisor

   // ==========================================================
   // Event bit positions, shared by status and enable registers
   localparam int unsigned EV_CTS  = 0;
   localparam int unsigned EV_CTSOFF = 1;
   localparam int unsigned EV_RXRDY = 2;
   localparam int unsigned EV_RXBUF = 4;
   localparam int unsigned EV_TXRDY = 7;
   localparam int unsigned EV_TXBUF = 8;
   localparam int unsigned EV_ERROR = 9;
   localparam int unsigned EV_RXTMO = 17;
   localparam int unsigned EV_RXST = 19;
   localparam int unsigned EV_TXST = 20;
   localparam int unsigned EV_TXSP = 22;
   localparam logic [31:0] EV_MASK = 32'h005A0397;

   // ==========================================================
   // Fields and reset values
   localparam int unsigned ERR_W      = 4;
   localparam logic [3:0]  ENABLE_ON  = 4'h8;
   localparam logic [3:0]  ENABLE_OFF = 4'h0;
   localparam int unsigned CFG_PAR    = 0;
   localparam int unsigned CFG_DIV_LO = 16;
   localparam int unsigned DIV_W      = 16;
   localparam logic [15:0] DIV_RESET  = 16'h00AD;
   localparam logic [3:0]  FRAME_NOPAR = 4'hA;
   localparam logic [3:0]  FRAME_PAR   = 4'hB;
   localparam logic [3:0]  LAST_BIT    = 4'h7;

   // Error flags, overrun in bit 0
   typedef struct packed {
      logic brk;
      logic framing;
      logic parity;
      logic overrun;
   } uie_err_t;

   // Event pulses from the transfer datapath
   typedef struct packed {
      logic clear_to_send_event;
      logic clear_to_send_deasserted_event;
      logic receive_buffer_full_event;
      logic transmit_byte_sent_event;
      logic transmit_buffer_done_event;
      logic receive_timeout_event;
      logic receive_started_event;
      logic transmit_started_event;
      logic transmit_stopped_event;
   } uie_evt_t;
endpackage : uie_pkg

/* File: rtl/uie_rx_monitor.sv */
`timescale 1ns/100ps
module uie_rx_monitor
   import uie_pkg::*;
#(
   parameter int unsigned DW = DIV_W
)(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          run,
   input  wire logic          parity_en,
   input  wire logic [DW-1:0] divisor,
   input  wire logic          rxd,
   output logic               start_seen,
   output logic [7:0]         rx_byte,
   output logic               byte_done,
   output uie_err_t           err
);
   typedef enum logic [2:0] {
      MON_IDLE  = 3'b000,
      MON_START = 3'b001,
      MON_DATA  = 3'b010,
      MON_PAR   = 3'b011,
      MON_STOP  = 3'b100
   } uie_mon_e_t;

   typedef struct packed {
      logic [2:0]    sync;
      logic          lvl;
      logic          armed;
      uie_mon_e_t    st;
      logic [DW-1:0] cnt;
      logic [3:0]    nbit;
      logic [7:0]    sh;
      logic          par;
      logic [DW-1:0] low_cnt;
      logic [3:0]    low_bits;
      logic          brk_done;
      logic          start_seen;
      logic          byte_done;
      logic [7:0]    rx_byte;
      uie_err_t      err;
   } uie_mon_t;

   uie_mon_t   s;
   uie_mon_t   next_s;
   logic [3:0] frame_len;

   assign frame_len = parity_en ? FRAME_PAR : FRAME_NOPAR;

   // ==========================================================
   // Line filter, break timer and character framer
   always_comb begin
      next_s = s;
      next_s.start_seen = 1'b0;
      next_s.byte_done = 1'b0;
      next_s.err = '0;
      // Level changes only once flops two and three agree
      next_s.sync = {s.sync[1:0], rxd};
      if (s.sync[1] == s.sync[2]) next_s.lvl = s.sync[2];
      // Break: low for a whole frame, reported once per low stretch
      if (!run || s.lvl) begin
         next_s.low_cnt = '0;
         next_s.low_bits = '0;
         next_s.brk_done = 1'b0;
      end else if (!s.brk_done) begin
         if (s.low_cnt == divisor - 1'b1) begin
            next_s.low_cnt = '0;
            next_s.low_bits = s.low_bits + 4'h1;
         end else begin
            next_s.low_cnt = s.low_cnt + 1'b1;
         end
         if (s.low_bits == frame_len) begin
            next_s.err.brk = 1'b1;
            next_s.brk_done = 1'b1;
         end
      end
      if (!run) begin
         next_s.st = MON_IDLE;
         next_s.armed = 1'b0;
      end else begin
         unique case (s.st)
            MON_IDLE: begin
               // Armed only after idle high, so a held-low line is no start
               if (s.lvl) next_s.armed = 1'b1;
               if (s.armed && !s.lvl) begin
                  next_s.st = MON_START;
                  next_s.cnt = divisor >> 1;
                  next_s.armed = 1'b0;
                  next_s.start_seen = 1'b1;
               end
            end
            MON_START: begin
               if (s.cnt == '0) begin
                  next_s.st = s.lvl ? MON_IDLE : MON_DATA;
                  next_s.cnt = divisor - 1'b1;
                  next_s.nbit = '0;
                  next_s.par = 1'b0;
               end else next_s.cnt = s.cnt - 1'b1;
            end
            MON_DATA: begin
               if (s.cnt == '0) begin
                  next_s.sh = {s.lvl, s.sh[7:1]};
                  next_s.par = s.par ^ s.lvl;
                  next_s.cnt = divisor - 1'b1;
                  next_s.nbit = s.nbit + 4'h1;
                  if (s.nbit == LAST_BIT) next_s.st = parity_en ? MON_PAR : MON_STOP;
               end else next_s.cnt = s.cnt - 1'b1;
            end
            MON_PAR: begin
               if (s.cnt == '0) begin
                  next_s.par = s.par ^ s.lvl;
                  next_s.cnt = divisor - 1'b1;
                  next_s.st = MON_STOP;
               end else next_s.cnt = s.cnt - 1'b1;
            end
            MON_STOP: begin
               if (s.cnt == '0) begin
                  next_s.st = MON_IDLE;
                  next_s.byte_done = 1'b1;
                  next_s.rx_byte = s.sh;
                  next_s.err.framing = !s.lvl;
                  next_s.err.parity = parity_en & s.par;
               end else next_s.cnt = s.cnt - 1'b1;
            end
            default: next_s.st = MON_IDLE;
         endcase
      end
   end

   // State register; line assumed idle high at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.sync <= 3'h7;
         s.lvl <= 1'b1;
      end else s <= next_s;
   end

   assign start_seen = s.start_seen;
   assign rx_byte = s.rx_byte;
   assign byte_done = s.byte_done;
   assign err = s.err;
endmodule : uie_rx_monitor

/* File: rtl/uie_irq_err.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module uie_irq_err
   import uie_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rxd,
   input  wire uie_evt_t          evt_in,
   input  wire logic              rx_holding_read,
   output logic [7:0]             rx_data,
   output logic                   peripheral_on,
   output logic                   irq
);
   typedef struct packed {
      logic [31:0]      inten;
      uie_err_t         errsrc;
      logic [31:0]      evt;
      logic [3:0]       enable;
      logic             parity_en;
      logic [DIV_W-1:0] divisor;
      logic [7:0]       rx_hold;
      logic             rx_unread;
      logic [31:0]      prdata;
      logic             slverr;
      logic             irq;
   } uie_main_t;

   uie_main_t   s;
   uie_main_t   next_s;
   logic        mon_start;
   logic [7:0]  mon_byte;
   logic        mon_done;
   uie_err_t    mon_err;
   uie_err_t    err_set;
   logic [31:0] ev_set;
   logic        setup;
   logic        wr;
   logic        rd;

   // ==========================================================
   // Serial line monitor
   uie_rx_monitor #(
      .DW (DIV_W)
   ) u_mon (
      .pclk       (pclk),
      .presetn    (presetn),
      .run        (peripheral_on),
      .parity_en  (s.parity_en),
      .divisor    (s.divisor),
      .rxd        (rxd),
      .start_seen (mon_start),
      .rx_byte    (mon_byte),
      .byte_done  (mon_done),
      .err        (mon_err)
   );

   // ==========================================================
   // Bus phases; access phase never waits
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & s.slverr;
   assign prdata = s.prdata;
   assign rx_data = s.rx_hold;
   assign irq = s.irq;
   assign peripheral_on = (s.enable == ENABLE_ON);

   // ==========================================================
   // Error and event sources
   always_comb begin
      err_set = mon_err;
      // Overrun counts only when the receiver is running
      err_set.overrun = mon_start & s.rx_unread & peripheral_on;
      ev_set = '0;
      if (peripheral_on) begin
         ev_set[EV_CTS] = evt_in.clear_to_send_event;
         ev_set[EV_CTSOFF] = evt_in.clear_to_send_deasserted_event;
         ev_set[EV_RXRDY] = mon_done;
         ev_set[EV_RXBUF] = evt_in.receive_buffer_full_event;
         ev_set[EV_TXRDY] = evt_in.transmit_byte_sent_event;
         ev_set[EV_TXBUF] = evt_in.transmit_buffer_done_event;
         ev_set[EV_RXTMO] = evt_in.receive_timeout_event;
         ev_set[EV_RXST] = evt_in.receive_started_event;
         ev_set[EV_TXST] = evt_in.transmit_started_event;
         ev_set[EV_TXSP] = evt_in.transmit_stopped_event;
      end
      ev_set[EV_ERROR] = |err_set;
   end

   // ==========================================================
   // Register file and status update
   always_comb begin
      next_s = s;
      // Read data is latched in the setup phase and held for access
      if (setup) begin
         next_s.prdata = '0;
         next_s.slverr = 1'b0;
         unique case (paddr)
            OFF_STAT: next_s.prdata = s.evt;
            OFF_INTEN, OFF_SET, OFF_CLR: next_s.prdata = s.inten;
            OFF_ERR: next_s.prdata = {{(32 - ERR_W){1'b0}}, s.errsrc};
            OFF_ENA: next_s.prdata = {28'h0000000, s.enable};
            OFF_CFG: begin
               next_s.prdata[CFG_PAR] = s.parity_en;
               next_s.prdata[CFG_DIV_LO +: DIV_W] = s.divisor;
            end
            default: next_s.slverr = 1'b1; // Unmapped: error, data zero
         endcase
      end
      if (wr) begin
         unique case (paddr)
            OFF_INTEN: next_s.inten = pwdata & EV_MASK;
            OFF_SET: next_s.inten = s.inten | (pwdata & EV_MASK);
            OFF_CLR: next_s.inten = s.inten & ~pwdata;
            OFF_ERR: next_s.errsrc = s.errsrc & ~pwdata[ERR_W-1:0];
            OFF_ENA: next_s.enable = pwdata[3:0];
            OFF_CFG: begin
               next_s.parity_en = pwdata[CFG_PAR];
               next_s.divisor = pwdata[CFG_DIV_LO +: DIV_W];
            end
            default: ;
         endcase
      end
      // Only the bits that were returned are cleared, so an event
      // arriving between setup and access is kept
      if (rd && paddr == OFF_STAT) next_s.evt = s.evt & ~s.prdata;
      // Hardware sets win over software clears
      next_s.errsrc = next_s.errsrc | err_set;
      next_s.evt = next_s.evt | ev_set;
      // Holding register: overrun drops the unread character
      if (rx_holding_read) next_s.rx_unread = 1'b0;
      if (err_set.overrun) next_s.rx_unread = 1'b0;
      if (mon_done) begin
         next_s.rx_hold = mon_byte;
         next_s.rx_unread = 1'b1;
      end
      next_s.irq = |(next_s.evt & next_s.inten);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.enable <= ENABLE_OFF;
         s.divisor <= DIV_RESET;
      end else s <= next_s;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   set_write_a: assert property (
      wr && paddr == OFF_SET |=>
         (s.inten & $past(pwdata) & EV_MASK) == ($past(pwdata) & EV_MASK))
      else $error("enable-set write did not enable the event");

   clr_write_a: assert property (
      wr && paddr == OFF_CLR |=> (s.inten & $past(pwdata)) == 32'h00000000)
      else $error("enable-clear write did not disable the event");

   direct_write_a: assert property (
      wr && paddr == OFF_INTEN |=> s.inten == ($past(pwdata) & EV_MASK))
      else $error("direct enable write not stored");

   err_sticky_a: assert property (
      !(wr && paddr == OFF_ERR) |=> (s.errsrc & $past(s.errsrc)) == $past(s.errsrc))
      else $error("error flag dropped without a clearing write");

   err_w1c_a: assert property (
      wr && paddr == OFF_ERR && pwdata[ERR_W-1:0] == 4'hF && !(|err_set)
         |=> s.errsrc == 4'h0)
      else $error("write of ones did not clear error flags");

   overrun_set_a: assert property (
      mon_start && s.rx_unread && peripheral_on |=> s.errsrc.overrun && !s.rx_unread)
      else $error("overrun not flagged or old character kept");

   parity_off_a: assert property (
      !s.parity_en |-> ##1 !mon_err.parity)
      else $error("parity error raised while checking is off");

   framing_flag_a: assert property (
      mon_err.framing |=> s.errsrc.framing)
      else $error("framing error not recorded");

   break_flag_a: assert property (
      mon_err.brk |=> s.errsrc.brk ##0 s.evt[EV_ERROR])
      else $error("break not recorded");

   flag_read_a: assert property (
      setup && paddr == OFF_ERR |=> s.prdata == {28'h0000000, $past(s.errsrc)})
      else $error("error flags read back wrong");

   rx_off_a: assert property (
      !peripheral_on [*2] |-> !mon_done && !mon_start)
      else $error("receiver active while switched off");

   // An enabled event must reach the pin even when a status read clears in the same cycle
   irq_level_a: assert property (
      |(ev_set & s.inten) && !(wr && (paddr == OFF_CLR || paddr == OFF_INTEN))
         |=> s.irq)
      else $error("interrupt output does not follow pending enabled events");

   // ==========================================================
   // Enable register views

   set_keeps_a: assert property (
      wr && paddr == OFF_SET |=> (s.inten & $past(s.inten)) == $past(s.inten))
      else $error("enable-set write cleared an enable");

   set_read_a: assert property (
      setup && paddr == OFF_SET |=> s.prdata == $past(s.inten))
      else $error("enable-set read does not show the enables");

   clr_keeps_a: assert property (
      wr && paddr == OFF_CLR |=> s.inten == ($past(s.inten) & ~$past(pwdata)))
      else $error("enable-clear write touched other enables");

   clr_read_a: assert property (
      setup && paddr == OFF_CLR |=> s.prdata == $past(s.inten))
      else $error("enable-clear read does not show the enables");

   direct_read_a: assert property (
      setup && paddr == OFF_INTEN |=> s.prdata == $past(s.inten))
      else $error("direct enable read does not show the enables");

   inten_hold_a: assert property (
      !(wr && (paddr == OFF_INTEN || paddr == OFF_SET || paddr == OFF_CLR))
         |=> s.inten == $past(s.inten))
      else $error("enables changed without a write");

   inten_legal_a: assert property (
      (s.inten & ~EV_MASK) == 32'h00000000)
      else $error("enable set for a bit with no event");

   // ==========================================================
   // Error flags, holding register and status

   err_zero_keep_a: assert property (
      wr && paddr == OFF_ERR && !(|err_set)
         |=> s.errsrc == ($past(s.errsrc) & ~$past(pwdata)))
      else $error("error flag write did not act bit by bit");

   err_flag_only_a: assert property (
      |(s.errsrc & ~$past(s.errsrc)) |-> |$past(err_set))
      else $error("error flag rose with no error");

   overrun_cause_a: assert property (
      $rose(s.errsrc.overrun) |-> $past(mon_start) && $past(s.rx_unread))
      else $error("overrun flagged without an unread character");

   rx_new_a: assert property (
      mon_done |=> s.rx_hold == $past(mon_byte) && s.rx_unread)
      else $error("received character not held");

   rx_unread_clear_a: assert property (
      rx_holding_read && !mon_done |=> !s.rx_unread)
      else $error("taken character still marked unread");

   parity_set_a: assert property (
      mon_err.parity |=> s.errsrc.parity)
      else $error("parity error not recorded");

   break_once_a: assert property (
      mon_err.brk |=> !mon_err.brk)
      else $error("break reported twice in a row");

   ena_write_a: assert property (
      wr && paddr == OFF_ENA |=>
         peripheral_on == (($past(pwdata) & 32'h0000000F) == 32'(ENABLE_ON)))
      else $error("enable field does not switch the receiver");

   evt_off_a: assert property (
      !peripheral_on && !(|err_set) |=> (s.evt & ~$past(s.evt)) == 32'h00000000)
      else $error("event latched while switched off");

   error_event_a: assert property (
      |err_set |=> s.evt[EV_ERROR])
      else $error("error flag did not raise the error event");

   stat_read_a: assert property (
      setup && paddr == OFF_STAT |=> s.prdata == $past(s.evt))
      else $error("status read does not show pending events");

   stat_clear_a: assert property (
      rd && paddr == OFF_STAT |=>
         (s.evt & $past(s.prdata) & ~$past(ev_set)) == 32'h00000000)
      else $error("status read did not clear the bits returned");

   cv_overrun: cover property (mon_start && s.rx_unread && peripheral_on);
   cv_break: cover property (mon_err.brk);
   cv_irq: cover property ($rose(s.irq));
   cv_stat_read: cover property (rd && paddr == OFF_STAT && s.prdata != 32'h00000000);
   cv_parity: cover property (mon_err.parity);
endmodule : uie_irq_err

/* File: testbench/uie_serial_peer.sv */
`timescale 1ns/100ps
// ==========================================================
// Remote serial transmitter driving the receive line
module uie_serial_peer #(
   parameter int unsigned DIV = 4
)(
   input  wire logic pclk,
   output logic      rxd
);
   // Line idles high, as a quiet transmitter leaves it
   initial rxd = 1'b1;

   // One bit time, changed just after a clock edge
   task automatic bit_out(input logic v);
      rxd <= v;
      repeat (DIV) @(posedge pclk);
   endtask : bit_out

   // Start, eight data bits LSB first, optional even parity, stop, idle gap
   task automatic send_char(input logic [7:0] d, input logic par_en, input logic par_bad,
                            input logic stop_bad);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) begin
         bit_out(d[i]);
      end
      if (par_en) begin
         bit_out(^d ^ par_bad);
      end
      bit_out(~stop_bad);
      bit_out(1'b1); // Gap so the next start edge follows a high level
   endtask : send_char

   // Hold the line low for a number of bit times, then release it high
   task automatic send_low(input int unsigned nbits);
      repeat (nbits) bit_out(1'b0);
      bit_out(1'b1);
   endtask : send_low
endmodule : uie_serial_peer

/* File: testbench/uart_irq_enable_error_flags_tb_top.sv */
`timescale 1ns/100ps
module uart_irq_enable_error_flags_tb_top;
   import uie_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
   logic        rxd, rx_holding_read, peripheral_on, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, w, exp_en;
   logic [7:0]  rx_data, ch;
   uie_evt_t    evt_in;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int unsigned pos [9] = '{EV_TXSP, EV_TXST, EV_RXST, EV_RXTMO, EV_TXBUF, EV_TXRDY,
                            EV_RXBUF, EV_CTSOFF, EV_CTS};
   logic [3:0]  ena_val [4] = '{4'h8, 4'h9, 4'h0, 4'h8};

   // ==========================================================
   // Clock, far side and device
   always #25 pclk = ~pclk;

   uie_serial_peer #(.DIV(4)) peer (.pclk(pclk), .rxd(rxd));

   uie_irq_err uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .evt_in(evt_in), .rx_holding_read(rx_holding_read),
      .rx_data(rx_data), .peripheral_on(peripheral_on), .irq(irq));

   // ==========================================================
   // Bench tasks
   task automatic tally_and_finish();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp

   // Expected enable state after a set or a clear write
   function automatic logic [31:0] en_after(input logic [31:0] cur, input logic [31:0] wv,
                                            input logic set);
      return set ? (cur | (wv & EV_MASK)) : (cur & ~wv);
   endfunction : en_after

   // One APB transfer; request held until pready is seen, then an idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_mismatch++; // A hung slave counts against the run
         tally_and_finish();
      end
      rd = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      cmp(nm, exp, rd);
   endtask : rd_chk

   task automatic hold_read();
      rx_holding_read <= 1'b1;
      @(posedge pclk);
      rx_holding_read <= 1'b0;
      @(posedge pclk);
   endtask : hold_read

   // Receive one character, check flags and, unless a framing error is expected, data, then clear the flags
   task automatic rx_char(input logic [7:0] d, input logic pe, input logic pb,
                          input logic sb, input logic [31:0] exp_err);
      peer.send_char(d, pe, pb, sb);
      repeat (6) @(posedge pclk);
      if (!exp_err[2]) cmp("received char", {24'h0, d}, {24'h0, rx_data});
      hold_read();
      rd_chk(OFF_ERR, exp_err, "error flags");
      apb(1'b1, OFF_ERR, 32'h0000000F);
   endtask : rx_char

   // ==========================================================
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      evt_in = '0;
      rx_holding_read = 1'b0;
      void'($urandom(32'hFD7C62E4));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(OFF_SET, 32'h0, "set reset");
      rd_chk(OFF_CLR, 32'h0, "clear reset");
      rd_chk(OFF_INTEN, 32'h0, "direct reset");
      rd_chk(OFF_ERR, 32'h0, "flags reset");
      rd_chk(OFF_ENA, 32'h0, "enable reset");
      rd_chk(12'hFFC, 32'h0, "unmapped data");
      cmp("unmapped error", 32'h1, {31'h0, last_err});
      // Random set and clear masks; all three views must track the same state
      exp_en = 32'h0;
      for (int i = 0; i < 8; i++) begin
         w = $urandom();
         apb(1'b1, OFF_SET, w);
         exp_en = en_after(exp_en, w, 1'b1);
         rd_chk(OFF_CLR, exp_en, "enable after set");
         w = $urandom();
         apb(1'b1, OFF_CLR, w);
         exp_en = en_after(exp_en, w, 1'b0);
         rd_chk(OFF_SET, exp_en, "enable after clear");
         rd_chk(OFF_INTEN, exp_en, "direct view");
      end
      w = $urandom();
      apb(1'b1, OFF_INTEN, w);
      rd_chk(OFF_SET, w & EV_MASK, "direct write");
      // Only the value eight switches the peripheral on
      foreach (ena_val[i]) begin
         apb(1'b1, OFF_ENA, {28'h0, ena_val[i]});
         cmp("peripheral on", {31'h0, ena_val[i] == 4'h8}, {31'h0, peripheral_on});
      end
      apb(1'b1, OFF_CFG, 32'h00040000);
      // Every datapath event raises its status bit and the interrupt
      apb(1'b1, OFF_INTEN, EV_MASK);
      for (int k = 0; k < 9; k++) begin
         evt_in <= uie_evt_t'(9'h001 << k);
         @(posedge pclk);
         evt_in <= '0;
         repeat (3) @(posedge pclk);
         cmp("irq on event", 32'h1, {31'h0, irq});
         rd_chk(OFF_STAT, 32'h1 << pos[k], "event status");
      end
      repeat (3) @(posedge pclk);
      cmp("irq after clear", 32'h0, {31'h0, irq});
      apb(1'b1, OFF_CLR, 32'h1 << EV_RXTMO);
      evt_in <= uie_evt_t'(9'h008);
      @(posedge pclk);
      evt_in <= '0;
      repeat (3) @(posedge pclk);
      cmp("masked irq", 32'h0, {31'h0, irq});
      rd_chk(OFF_STAT, 32'h1 << EV_RXTMO, "masked status");
      // Serial reception and error flags
      for (int i = 0; i < 4; i++) begin
         ch = 8'($urandom());
         rx_char(ch, 1'b0, 1'b0, 1'b0, 32'h0);
      end
      apb(1'b1, OFF_CFG, 32'h00040001);
      rx_char(8'($urandom()), 1'b1, 1'b0, 1'b0, 32'h0);
      rx_char(8'h5A, 1'b1, 1'b1, 1'b0, 32'h2);
      apb(1'b1, OFF_CFG, 32'h00040000);
      rx_char(8'h55, 1'b0, 1'b0, 1'b1, 32'h4);
      peer.send_char(8'h11, 1'b0, 1'b0, 1'b0);
      rx_char(8'h22, 1'b0, 1'b0, 1'b0, 32'h1);
      peer.send_low(9);
      repeat (6) @(posedge pclk);
      hold_read();
      rd_chk(OFF_ERR, 32'h0, "low within frame");
      // Receiver switched off ignores a broken frame
      apb(1'b1, OFF_ENA, 32'h0);
      peer.send_char(8'h55, 1'b0, 1'b0, 1'b1);
      repeat (6) @(posedge pclk);
      rd_chk(OFF_ERR, 32'h0, "flags while off");
      apb(1'b1, OFF_ENA, 32'h8);
      // Break raises the error event; flags clear only on a written one
      apb(1'b1, OFF_INTEN, 32'h1 << EV_ERROR);
      apb(1'b0, OFF_STAT, 32'h0);
      peer.send_low(12);
      repeat (6) @(posedge pclk);
      cmp("error irq", 32'h1, {31'h0, irq});
      apb(1'b0, OFF_ERR, 32'h0);
      cmp("break flag", 32'h8, rd & 32'h8);
      apb(1'b1, OFF_ERR, 32'h0);
      apb(1'b0, OFF_ERR, 32'h0);
      cmp("zero write keeps", 32'h8, rd & 32'h8);
      apb(1'b1, OFF_ERR, 32'h0000000F);
      rd_chk(OFF_ERR, 32'h0, "one write clears");
      hold_read();
      apb(1'b0, OFF_STAT, 32'h0);
      apb(1'b0, OFF_STAT, 32'h0);
      repeat (3) @(posedge pclk);
      cmp("irq released", 32'h0, {31'h0, irq});
      tally_and_finish();
   end
endmodule : uart_irq_enable_error_flags_tb_top
